/* File: hw/port_def_function_select_mux.sv */
// Function select registers and pin route decode for ports D, E, F
// plus secondary selections on A3, B1, B5, E7, F1 and F2.
// Assumes the extended-register strobes and the port A3 primary field
// come from logic on ref_clk; pins themselves are muxed elsewhere.
//
// Summary of operation
// - D7..D4: GPIO, segment A, reserved, common B
// - D3..D0: GPIO, segment A, segment B, common B
// - All select registers reset to zero
// - E7: GPIO, segment A18, SPI clock, legacy bit
// - A3 as I2C data forces E7 to clock unless the E7 secondary bit is set
// - E6: GPIO, segment A17, timer input, ADC15
// - E5: GPIO, segment A16, UART receive, ADC14
// - E5 UART receive forces E6 to transmit
// - E4: GPIO, segment A15, reserved, ADC13
// - E3: GPIO, segment A14, buzzer C, ADC12
// - E2: GPIO, segment A13, PWM5 B, ADC11
// - E1/E0: GPIO, segment, reserved, ADC
// - Port F bit 7 routes F3 to reset
// - F2: GPIO, comparator out, capture/strobe, legacy
// - F1: GPIO/comparator, timer clock, SPI, legacy
// - F0: GPIO/comparator, PWM0 A, overflow, buzzer A
// - A3 secondary bit overrides to PWM3 A
// - B5 secondary: defer, reserved, legacy bit
// - B1 secondary: defer, PWM4 B, reserved, legacy
// - E7 secondary bit selects PWM1 B
// - F2 secondary bit selects PWM3 B
// - F1 secondary bit selects PWM2 B
`default_nettype none

module port_def_function_select_mux
    import pin_mux_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  external_reset_in,
    // Extended register access
    input  wire logic [ADDR_W-1:0]     xfr_addr,
    input  wire logic [DATA_W-1:0]     xfr_wdata,
    input  wire logic                  xfr_wr,
    input  wire logic                  xfr_rd,
    output logic      [DATA_W-1:0]     xfr_rdata,
    output logic                       xfr_rvalid,
    // Port A3 primary field from the port A select logic
    input  wire logic [FIELD_W-1:0]    porta3_primary_field,
    // Effective routes, one code per pin
    output logic [8*ROUTE_W-1:0]       portd_route,
    output logic [8*ROUTE_W-1:0]       porte_route,
    output logic [4*ROUTE_W-1:0]       portf_route,
    output logic [ROUTE_W-1:0]         porta3_route,
    output logic [ROUTE_W-1:0]         portb5_route,
    output logic [ROUTE_W-1:0]         portb1_route
);

    // ****************************************
    // Register file
    // ****************************************
    logic [DATA_W-1:0] port_d_high_pin_select_q;
    logic [DATA_W-1:0] port_d_low_pin_select_q;
    logic [DATA_W-1:0] port_e_high_pin_select_q;
    logic [DATA_W-1:0] port_e_low_pin_select_q;
    logic [DATA_W-1:0] port_f_pin_select_q;
    logic [DATA_W-1:0] port_a_secondary_select_q;
    logic [DATA_W-1:0] port_b5_secondary_select_q;
    logic [DATA_W-1:0] port_b1_secondary_select_q;
    logic [DATA_W-1:0] port_e_secondary_select_q;
    logic [DATA_W-1:0] port_f_secondary_select_q;

    // Writes store only implemented bits so reserved bits stay zero
    always_ff @(posedge ref_clk)
    begin
        if (!external_reset_in)
        begin
            port_d_high_pin_select_q   <= REG_RESET;
            port_d_low_pin_select_q    <= REG_RESET;
            port_e_high_pin_select_q   <= REG_RESET;
            port_e_low_pin_select_q    <= REG_RESET;
            port_f_pin_select_q        <= REG_RESET;
            port_a_secondary_select_q  <= REG_RESET;
            port_b5_secondary_select_q <= REG_RESET;
            port_b1_secondary_select_q <= REG_RESET;
            port_e_secondary_select_q  <= REG_RESET;
            port_f_secondary_select_q  <= REG_RESET;
        end
        else if (xfr_wr)
        begin
            case (xfr_addr)
                OFF_PD_HIGH: port_d_high_pin_select_q   <= xfr_wdata & MASK_FULL;
                OFF_PD_LOW:  port_d_low_pin_select_q    <= xfr_wdata & MASK_FULL;
                OFF_PE_HIGH: port_e_high_pin_select_q   <= xfr_wdata & MASK_FULL;
                OFF_PE_LOW:  port_e_low_pin_select_q    <= xfr_wdata & MASK_FULL;
                OFF_PF:      port_f_pin_select_q        <= xfr_wdata & MASK_PF;
                OFF_PA_SEC:  port_a_secondary_select_q  <= xfr_wdata & MASK_PA_SEC;
                OFF_PB5_SEC: port_b5_secondary_select_q <= xfr_wdata & MASK_PB_SEC;
                OFF_PB1_SEC: port_b1_secondary_select_q <= xfr_wdata & MASK_PB_SEC;
                OFF_PE_SEC:  port_e_secondary_select_q  <= xfr_wdata & MASK_PE_SEC;
                OFF_PF_SEC:  port_f_secondary_select_q  <= xfr_wdata & MASK_PF_SEC;
                default:     ;
            endcase
        end
    end

    // Read data is registered; unmapped addresses return zero
    always_ff @(posedge ref_clk)
    begin
        if (!external_reset_in)
        begin
            xfr_rdata  <= REG_RESET;
            xfr_rvalid <= 1'b0;
        end
        else
        begin
            xfr_rvalid <= xfr_rd;
            case (xfr_addr)
                OFF_PD_HIGH: xfr_rdata <= port_d_high_pin_select_q;
                OFF_PD_LOW:  xfr_rdata <= port_d_low_pin_select_q;
                OFF_PE_HIGH: xfr_rdata <= port_e_high_pin_select_q;
                OFF_PE_LOW:  xfr_rdata <= port_e_low_pin_select_q;
                OFF_PF:      xfr_rdata <= port_f_pin_select_q;
                OFF_PA_SEC:  xfr_rdata <= port_a_secondary_select_q;
                OFF_PB5_SEC: xfr_rdata <= port_b5_secondary_select_q;
                OFF_PB1_SEC: xfr_rdata <= port_b1_secondary_select_q;
                OFF_PE_SEC:  xfr_rdata <= port_e_secondary_select_q;
                OFF_PF_SEC:  xfr_rdata <= port_f_secondary_select_q;
                default:     xfr_rdata <= REG_RESET;
            endcase
        end
    end

    // ****************************************
    // Field extraction
    // ****************************************
    logic [2*DATA_W-1:0] port_d_fields;
    logic [2*DATA_W-1:0] port_e_fields;
    logic [FIELD_W-1:0]  porte_pin5_select;
    logic [FIELD_W-1:0]  portf_pin2_select;
    logic [FIELD_W-1:0]  portf_pin1_select;
    logic [FIELD_W-1:0]  portf_pin0_select;
    logic [FIELD_W-1:0]  portb5_secondary;
    logic [FIELD_W-1:0]  portb1_secondary;
    logic                portf_pin3_reset_select;
    logic                porta_pin3_secondary;
    logic                porte_pin7_secondary;
    logic                portf_pin2_secondary;
    logic                portf_pin1_secondary;
    logic                i2c_pair_active;
    logic                uart_pair_active;

    // Low register holds pins 3..0, high register pins 7..4
    assign port_d_fields           = {port_d_high_pin_select_q, port_d_low_pin_select_q};
    assign port_e_fields           = {port_e_high_pin_select_q, port_e_low_pin_select_q};
    assign porte_pin5_select       = port_e_fields[5*FIELD_W +: FIELD_W];
    assign portf_pin2_select       = port_f_pin_select_q[PF2_LSB +: FIELD_W];
    assign portf_pin1_select       = port_f_pin_select_q[PF1_LSB +: FIELD_W];
    assign portf_pin0_select       = port_f_pin_select_q[PF0_LSB +: FIELD_W];
    assign portf_pin3_reset_select = port_f_pin_select_q[PF_RESET_BIT];
    assign porta_pin3_secondary    = port_a_secondary_select_q[PA3_SEC_BIT];
    assign portb5_secondary        = port_b5_secondary_select_q[PB_SEC_LSB +: FIELD_W];
    assign portb1_secondary        = port_b1_secondary_select_q[PB_SEC_LSB +: FIELD_W];
    assign porte_pin7_secondary    = port_e_secondary_select_q[PE7_SEC_BIT];
    assign portf_pin2_secondary    = port_f_secondary_select_q[PF2_SEC_BIT];
    assign portf_pin1_secondary    = port_f_secondary_select_q[PF1_SEC_BIT];
    // Pairing overrides taken from neighbouring pins
    assign i2c_pair_active         = (porta3_primary_field == SEL_ALT1);
    assign uart_pair_active        = (porte_pin5_select == SEL_ALT2);

    // ****************************************
    // Port D and port E route decode
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < 2*PINS_PER_REG; i++)
        begin : g_pin
            // Alternate-2 meaning differs per pin; reserved slots fall back to GPIO
            localparam logic [3:0] E_ALT2 = (i == 7) ? FN_SPI    :
                                            (i == 6) ? FN_TIMER  :
                                            (i == 5) ? FN_UART   :
                                            (i == 3) ? FN_BUZZER :
                                            (i == 2) ? FN_PWM    : FN_GPIO;
            localparam logic [3:0] E_ALT3 = (i == 7) ? FN_LEGACY_P0 : FN_ADC;
            localparam logic [3:0] D_ALT2 = (i < PINS_PER_REG) ? FN_SEG_B : FN_GPIO;
            logic [FIELD_W-1:0] d_sel;
            logic [FIELD_W-1:0] e_sel;
            logic [ROUTE_W-1:0] d_fn;
            logic [ROUTE_W-1:0] e_base;
            logic [ROUTE_W-1:0] e_fn;

            assign d_sel = port_d_fields[i*FIELD_W +: FIELD_W];
            assign e_sel = port_e_fields[i*FIELD_W +: FIELD_W];

            // Port D decode
            always_comb
            begin
                case (d_sel)
                    SEL_ALT1: d_fn = FN_SEG_A;
                    SEL_ALT2: d_fn = D_ALT2;
                    SEL_ALT3: d_fn = FN_COM_B;
                    default:  d_fn = FN_GPIO;
                endcase
            end

            // Port E base decode from the pin's own field
            always_comb
            begin
                case (e_sel)
                    SEL_ALT1: e_base = FN_SEG_A;
                    SEL_ALT2: e_base = E_ALT2;
                    SEL_ALT3: e_base = E_ALT3;
                    default:  e_base = FN_GPIO;
                endcase
            end

            // Overrides: E7 secondary over the I2C pairing, E6 taken by UART pairing
            always_comb
            begin
                e_fn = e_base;
                if (i == 7)
                begin
                    if (porte_pin7_secondary)
                        e_fn = FN_PWM;
                    else if (i2c_pair_active)
                        e_fn = FN_I2C;
                end
                else if (i == 6)
                begin
                    if (uart_pair_active)
                        e_fn = FN_UART;
                end
            end

            // Routes registered so the pad mux sees glitch-free selects
            always_ff @(posedge ref_clk)
            begin
                if (!external_reset_in)
                begin
                    portd_route[i*ROUTE_W +: ROUTE_W] <= FN_GPIO;
                    porte_route[i*ROUTE_W +: ROUTE_W] <= FN_GPIO;
                end
                else
                begin
                    portd_route[i*ROUTE_W +: ROUTE_W] <= d_fn;
                    porte_route[i*ROUTE_W +: ROUTE_W] <= e_fn;
                end
            end
        end
    endgenerate

    // ****************************************
    // Port F, A3, B5, B1 route decode
    // ****************************************
    logic [ROUTE_W-1:0] f3_fn;
    logic [ROUTE_W-1:0] f2_fn;
    logic [ROUTE_W-1:0] f1_fn;
    logic [ROUTE_W-1:0] f0_fn;
    logic [ROUTE_W-1:0] a3_fn;
    logic [ROUTE_W-1:0] b5_fn;
    logic [ROUTE_W-1:0] b1_fn;

    // Comparator inputs ride on the GPIO code; software keeps the pin an input
    always_comb
    begin
        f3_fn = portf_pin3_reset_select ? FN_RESET : FN_GPIO;
        case (portf_pin2_select)
            SEL_ALT1: f2_fn = FN_CMP_OUT;
            SEL_ALT2: f2_fn = FN_TIMER;
            SEL_ALT3: f2_fn = FN_LEGACY_P0;
            default:  f2_fn = FN_GPIO;
        endcase
        if (portf_pin2_secondary)
            f2_fn = FN_PWM;
        case (portf_pin1_select)
            SEL_ALT1: f1_fn = FN_TIMER;
            SEL_ALT2: f1_fn = FN_SPI;
            SEL_ALT3: f1_fn = FN_LEGACY_P0;
            default:  f1_fn = FN_GPIO;
        endcase
        if (portf_pin1_secondary)
            f1_fn = FN_PWM;
        case (portf_pin0_select)
            SEL_ALT1: f0_fn = FN_PWM;
            SEL_ALT2: f0_fn = FN_TIMER;
            SEL_ALT3: f0_fn = FN_BUZZER;
            default:  f0_fn = FN_GPIO;
        endcase
    end

    // Secondary selects; primary code means the port's own field decides
    always_comb
    begin
        a3_fn = porta_pin3_secondary ? FN_PWM : FN_PRIMARY;
        case (portb5_secondary)
            SEL_ALT3: b5_fn = FN_LEGACY_P0;
            SEL_GPIO: b5_fn = FN_PRIMARY;
            default:  b5_fn = FN_GPIO;
        endcase
        case (portb1_secondary)
            SEL_ALT1: b1_fn = FN_PWM;
            SEL_ALT3: b1_fn = FN_LEGACY_P0;
            SEL_GPIO: b1_fn = FN_PRIMARY;
            default:  b1_fn = FN_GPIO;
        endcase
    end

    // Route registers for the remaining pins
    always_ff @(posedge ref_clk)
    begin
        if (!external_reset_in)
        begin
            portf_route  <= {4{FN_GPIO}};
            porta3_route <= FN_PRIMARY;
            portb5_route <= FN_PRIMARY;
            portb1_route <= FN_PRIMARY;
        end
        else
        begin
            portf_route  <= {f3_fn, f2_fn, f1_fn, f0_fn};
            porta3_route <= a3_fn;
            portb5_route <= b5_fn;
            portb1_route <= b1_fn;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!external_reset_in);

    property p_reset_clear;
        $rose(external_reset_in) |-> (port_f_pin_select_q == REG_RESET)
            && (port_e_fields == '0) && (port_d_fields == '0)
            && (portf_route == '0) && (porte_route == '0);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("select not cleared by reset");

    property p_d7_common;
        (port_d_fields[7*FIELD_W +: FIELD_W] == SEL_ALT3)
            |=> (portd_route[7*ROUTE_W +: ROUTE_W] == FN_COM_B);
    endproperty
    a_d7_common: assert property (p_d7_common) else $error("D7 common route wrong");

    property p_d_reserved;
        (port_d_fields[4*FIELD_W +: FIELD_W] == SEL_ALT2) ##1
        (port_d_fields[0 +: FIELD_W] == SEL_ALT2)
            |-> (portd_route[4*ROUTE_W +: ROUTE_W] == FN_GPIO) ##1
                (portd_route[0 +: ROUTE_W] == FN_SEG_B);
    endproperty
    a_d_reserved: assert property (p_d_reserved) else $error("D alt2 route wrong");

    property p_i2c_pair;
        (i2c_pair_active && !porte_pin7_secondary)
            |=> (porte_route[7*ROUTE_W +: ROUTE_W] == FN_I2C);
    endproperty
    a_i2c_pair: assert property (p_i2c_pair) else $error("E7 not forced to I2C clock");

    property p_e7_spi;
        (port_e_fields[7*FIELD_W +: FIELD_W] == SEL_ALT2) && !i2c_pair_active
            && !porte_pin7_secondary |=> (porte_route[7*ROUTE_W +: ROUTE_W] == FN_SPI);
    endproperty
    a_e7_spi: assert property (p_e7_spi) else $error("E7 SPI clock route wrong");

    property p_uart_pair;
        uart_pair_active |=> (porte_route[6*ROUTE_W +: ROUTE_W] == FN_UART)
            && (porte_route[5*ROUTE_W +: ROUTE_W] == FN_UART);
    endproperty
    a_uart_pair: assert property (p_uart_pair) else $error("UART pair not routed");

    property p_f3_reset;
        $rose(portf_pin3_reset_select) |=> (portf_route[3*ROUTE_W +: ROUTE_W] == FN_RESET);
    endproperty
    a_f3_reset: assert property (p_f3_reset) else $error("F3 reset route wrong");

    property p_a3_pwm;
        porta_pin3_secondary |=> (porta3_route == FN_PWM);
    endproperty
    a_a3_pwm: assert property (p_a3_pwm) else $error("A3 PWM override missing");

    property p_f2_pwm;
        portf_pin2_secondary |=> (portf_route[2*ROUTE_W +: ROUTE_W] == FN_PWM);
    endproperty
    a_f2_pwm: assert property (p_f2_pwm) else $error("F2 PWM override missing");

    property p_reserved_zero;
        (xfr_wr && xfr_addr == OFF_PF && xfr_wdata == MASK_FULL)
            |=> (port_f_pin_select_q == MASK_PF);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit stored");

    c_i2c_pair:  cover property (i2c_pair_active ##1 porte_route[7*ROUTE_W +: ROUTE_W] == FN_I2C);
    c_uart_pair: cover property (uart_pair_active ##1 porte_route[6*ROUTE_W +: ROUTE_W] == FN_UART);
    c_f3_reset:  cover property (portf_route[3*ROUTE_W +: ROUTE_W] == FN_RESET);
    c_b1_pwm:    cover property (portb1_route == FN_PWM);

endmodule

`default_nettype wire

/* File: pkg/pin_mux_pkg.sv */
// Constants for the port D/E/F function select multiplexer.
// Assumes an 8-bit extended register space reached by address,
// with single-cycle read and write strobes on the system clock.
`default_nettype none

package pin_mux_pkg;

    // ****************************************
    // Register offsets in extended space
    // ****************************************
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 8;
    localparam logic [15:0] OFF_PD_HIGH     = 16'h002B;
    localparam logic [15:0] OFF_PD_LOW      = 16'h002C;
    localparam logic [15:0] OFF_PE_HIGH     = 16'h002D;
    localparam logic [15:0] OFF_PE_LOW      = 16'h002E;
    localparam logic [15:0] OFF_PF          = 16'h002F;
    localparam logic [15:0] OFF_PA_SEC      = 16'h0221;
    localparam logic [15:0] OFF_PB5_SEC     = 16'h0222;
    localparam logic [15:0] OFF_PB1_SEC     = 16'h0223;
    localparam logic [15:0] OFF_PE_SEC      = 16'h0228;
    localparam logic [15:0] OFF_PF_SEC      = 16'h022B;

    // ****************************************
    // Reset value and implemented-bit masks
    // ****************************************
    localparam logic [7:0]  REG_RESET       = 8'h00;
    localparam logic [7:0]  MASK_FULL       = 8'hFF;
    localparam logic [7:0]  MASK_PF         = 8'hBF;
    localparam logic [7:0]  MASK_PA_SEC     = 8'h40;
    localparam logic [7:0]  MASK_PB_SEC     = 8'h0C;
    localparam logic [7:0]  MASK_PE_SEC     = 8'h40;
    localparam logic [7:0]  MASK_PF_SEC     = 8'h14;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int          FIELD_W         = 2;
    localparam int          PINS_PER_REG    = 4;
    localparam int          PF_RESET_BIT    = 7;
    localparam int          PF2_LSB         = 4;
    localparam int          PF1_LSB         = 2;
    localparam int          PF0_LSB         = 0;
    localparam int          PA3_SEC_BIT     = 6;
    localparam int          PB_SEC_LSB      = 2;
    localparam int          PE7_SEC_BIT     = 6;
    localparam int          PF2_SEC_BIT     = 4;
    localparam int          PF1_SEC_BIT     = 2;

    // ****************************************
    // Select codes
    // ****************************************
    localparam logic [1:0]  SEL_GPIO        = 2'h0;
    localparam logic [1:0]  SEL_ALT1        = 2'h1;
    localparam logic [1:0]  SEL_ALT2        = 2'h2;
    localparam logic [1:0]  SEL_ALT3        = 2'h3;

    // ****************************************
    // Effective pin route codes
    // ****************************************
    localparam int          ROUTE_W         = 4;
    localparam logic [3:0]  FN_GPIO         = 4'h0;
    localparam logic [3:0]  FN_SEG_A        = 4'h1;
    localparam logic [3:0]  FN_SEG_B        = 4'h2;
    localparam logic [3:0]  FN_COM_B        = 4'h3;
    localparam logic [3:0]  FN_SPI          = 4'h4;
    localparam logic [3:0]  FN_LEGACY_P0    = 4'h5;
    localparam logic [3:0]  FN_I2C          = 4'h6;
    localparam logic [3:0]  FN_TIMER        = 4'h7;
    localparam logic [3:0]  FN_ADC          = 4'h8;
    localparam logic [3:0]  FN_UART         = 4'h9;
    localparam logic [3:0]  FN_BUZZER       = 4'hA;
    localparam logic [3:0]  FN_PWM          = 4'hB;
    localparam logic [3:0]  FN_CMP_OUT      = 4'hC;
    localparam logic [3:0]  FN_RESET        = 4'hD;
    localparam logic [3:0]  FN_PRIMARY      = 4'hE;

endpackage

`default_nettype wire

/* File: dv/porta_select_model.sv */
// Behavioural port A select logic that feeds the A3 primary field.
// Assumes the bench asks for a field value; it shows one edge later.
`default_nettype none

module porta_select_model
    import pin_mux_pkg::*;
(
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               external_reset_in,
    // Requested and presented field
    input  wire logic [FIELD_W-1:0] field_req,
    output logic      [FIELD_W-1:0] field_q
);
    timeunit 1ns;
    timeprecision 1ps;

    // Field clears on reset like the real select register; code 01 asks for I2C data
    // Pad type of a shared I2C pin is software's: open-drain with a pull-up
    always_ff @(posedge ref_clk)
    begin
        field_q <= external_reset_in ? field_req : '0;
    end
endmodule

`default_nettype wire

/* File: dv/port_def_function_select_mux_tb.sv */
// Self-checking bench: random register writes checked against a table model.
// Assumes the package constants and single-cycle strobes on ref_clk.
`default_nettype none

module port_def_function_select_mux_tb;
    import pin_mux_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR %0t mismatch %h vs %h", $time, a, b); end end
    logic        ref_clk = 1'b0;
    logic        external_reset_in = 1'b0;
    logic        xfr_wr = 1'b0;
    logic        xfr_rd = 1'b0;
    logic [15:0] xfr_addr = 16'h0000;
    logic [7:0]  xfr_wdata = 8'h00;
    logic [1:0]  a3_req = 2'h0;
    logic [1:0]  a3_field;
    logic [7:0]  xfr_rdata;
    logic        xfr_rvalid;
    logic [31:0] portd_route;
    logic [31:0] porte_route;
    logic [15:0] portf_route;
    logic [3:0]  porta3_route;
    logic [3:0]  portb5_route;
    logic [3:0]  portb1_route;
    int          mismatches = 0;
    int          n_checks = 0;
    int          regs [11] = '{default: 0};
    int          a3 = 0;
    int          k;
    // Last entry is an unmapped address; its zero mask keeps the model at zero
    localparam logic [15:0] ADDRS [11] = '{OFF_PD_HIGH, OFF_PD_LOW, OFF_PE_HIGH, OFF_PE_LOW,
        OFF_PF, OFF_PA_SEC, OFF_PB5_SEC, OFF_PB1_SEC, OFF_PE_SEC, OFF_PF_SEC, 16'h0030};
    localparam int MASKS [11] = '{255, 255, 255, 255, 191, 64, 12, 12, 64, 20, 0};
    localparam int DT [2][4] = '{'{0, 1, 0, 3}, '{0, 1, 2, 3}};
    localparam int ET [8][4] = '{'{0, 1, 0, 8}, '{0, 1, 0, 8}, '{0, 1, 11, 8}, '{0, 1, 10, 8},
        '{0, 1, 0, 8}, '{0, 1, 9, 8}, '{0, 1, 7, 8}, '{0, 1, 4, 5}};
    localparam int FT [3][4] = '{'{0, 11, 7, 10}, '{0, 7, 4, 5}, '{0, 12, 7, 5}};
    localparam int B5T [4] = '{14, 0, 0, 5};
    localparam int B1T [4] = '{14, 11, 0, 5};

    porta_select_model part_u (.ref_clk(ref_clk), .external_reset_in(external_reset_in), .field_req(a3_req),
        .field_q(a3_field));
    port_def_function_select_mux dut_u (.ref_clk(ref_clk), .external_reset_in(external_reset_in), .xfr_addr(xfr_addr),
        .xfr_wdata(xfr_wdata), .xfr_wr(xfr_wr), .xfr_rd(xfr_rd), .xfr_rdata(xfr_rdata),
        .xfr_rvalid(xfr_rvalid), .porta3_primary_field(a3_field), .portd_route(portd_route),
        .porte_route(porte_route), .portf_route(portf_route), .porta3_route(porta3_route),
        .portb5_route(portb5_route), .portb1_route(portb1_route));

    // 50 MHz system clock
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end

    // Tasks are entered just after a rising edge and leave just after one
    task automatic wr_reg(input int idx, input logic [7:0] d);
        xfr_addr = ADDRS[idx];
        xfr_wdata = d;
        xfr_wr = 1'b1;
        @(posedge ref_clk) #1;
        xfr_wr = 1'b0;
        regs[idx] = int'(d) & MASKS[idx];
    endtask

    task automatic rd_reg(input int idx);
        xfr_addr = ADDRS[idx];
        xfr_rd = 1'b1;
        @(posedge ref_clk) #1;
        xfr_rd = 1'b0;
        `CHK(xfr_rvalid, 1'b1)
        `CHK(xfr_rdata, 8'(regs[idx]))
        // Idle edge keeps back-to-back reads from re-raising the strobe in one step
        @(posedge ref_clk) #1;
        `CHK(xfr_rvalid, 1'b0)
    endtask

    // Forced pairings are applied over the plain field tables
    task automatic check_routes;
        logic [31:0] ed;
        logic [31:0] ee;
        logic [15:0] ef;
        for (int i = 0; i < 8; i++)
        begin
            ed[4*i+:4] = 4'(DT[i >= 4 ? 0 : 1][(regs[i >= 4 ? 0 : 1] >> (2*(i%4))) & 3]);
            ee[4*i+:4] = 4'(ET[i][(regs[i >= 4 ? 2 : 3] >> (2*(i%4))) & 3]);
        end
        if (((regs[2] >> 2) & 3) == 2) ee[27:24] = 4'h9;
        if (a3 == 1) ee[31:28] = 4'h6;
        if (regs[8][6]) ee[31:28] = 4'hB;
        for (int i = 0; i < 3; i++) ef[4*i+:4] = 4'(FT[i][(regs[4] >> (2*i)) & 3]);
        ef[15:12] = regs[4][7] ? 4'hD : 4'h0;
        if (regs[9][4]) ef[11:8] = 4'hB;
        if (regs[9][2]) ef[7:4] = 4'hB;
        `CHK(portd_route, ed)
        `CHK(porte_route, ee)
        `CHK(portf_route, ef)
        `CHK(porta3_route, (regs[5][6] ? 4'hB : 4'hE))
        `CHK(portb5_route, 4'(B5T[(regs[6] >> 2) & 3]))
        `CHK(portb1_route, 4'(B1T[(regs[7] >> 2) & 3]))
    endtask

    task automatic check_all;
        check_routes();
        for (int i = 0; i < 11; i++) rd_reg(i);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence: reset, all-ones pass, random traffic, second reset at the end
    initial
    begin
        void'($urandom(32'hFE666570));
        repeat (6) @(posedge ref_clk);
        #1 external_reset_in = 1'b1;
        check_all();
        // All ones everywhere: reserved bits must drop, unmapped write ignored
        for (int i = 0; i < 11; i++)
        begin
            wr_reg(i, 8'hFF);
            @(posedge ref_clk) #1;
        end
        check_all();
        repeat (300)
        begin
            k = $urandom_range(10);
            a3_req = 2'($urandom);
            a3 = int'(a3_req);
            wr_reg(k, 8'($urandom));
            @(posedge ref_clk) #1;
            check_routes();
            rd_reg(k);
        end
        a3_req = 2'h0;
        external_reset_in = 1'b0;
        repeat (2) @(posedge ref_clk) #1;
        external_reset_in = 1'b1;
        regs = '{default: 0};
        a3 = 0;
        check_all();
        summarize();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #400000;
        mismatches++;
        summarize();
    end
endmodule

`default_nettype wire
